/* File: tb/ata_link_assertions.sv */
/*
 * concurrent checks on the task file link that joins the two ends.
 * assumes the bench hands in hclk, hresetn and the link signals by name.
 */
`default_nettype none
module ata_link_assertions (
	input wire logic        hclk,    // clock
	input wire logic        hresetn, // async reset, active low
	input wire logic        stb,     // access strobe
	input wire logic        we,      // write access
	input wire logic [2:0]  addr,    // task file address
	input wire logic        wide,    // word access
	input wire logic [15:0] wdata,   // write data
	input wire logic        ack,     // answer pulse
	input wire logic [15:0] rdata,   // read data
	input wire logic        intrq    // device interrupt
);
	logic [7:0] count_reg;
	logic       long_reg;
	logic [8:0] xfer_reg;
	logic       cmd_wr;
	logic       data_rd;
	logic       stat_rd;
	assign cmd_wr  = stb && we && addr == ata_pkg::TF_STATUS;
	assign data_rd = stb && !we && addr == ata_pkg::TF_DATA;
	assign stat_rd = stb && !we && addr == ata_pkg::TF_STATUS;
	// counts data reads of the running long command to see where word mode ends
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_reg <= 8'h01;
			long_reg  <= 1'b0;
			xfer_reg  <= 9'h000;
		end else begin
			if (stb && we && addr == ata_pkg::TF_COUNT)
				count_reg <= wdata[7:0];
			if (cmd_wr) begin
				long_reg <= wdata[7:0] == ata_pkg::CMD_LONG_RT || wdata[7:0] == ata_pkg::CMD_LONG_NR;
				xfer_reg <= 9'h000;
			end else if (data_rd && long_reg)
				xfer_reg <= xfer_reg + 9'h001;
		end
	end
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	ack_follows_a: assert property (stb |=> ack) else $error("no answer one cycle after strobe");
	ack_pulse_a: assert property (ack |=> !ack) else $error("answer longer than one cycle");
	stb_spacing_a: assert property (stb |=> !stb) else $error("strobe before answer");
	rdata_hold_a: assert property (!(stb && !we) |=> $stable(rdata)) else $error("read data moved without a read");
	head_fixed_a: assert property (stb && we && addr == ata_pkg::TF_DEVHEAD |-> wdata[7] && wdata[5])
		else $error("fixed head bits not set");
	long_count_a: assert property (cmd_wr && (wdata[7:0] == ata_pkg::CMD_LONG_RT
		|| wdata[7:0] == ata_pkg::CMD_LONG_NR) |-> count_reg == ata_pkg::LONG_COUNT)
		else $error("long read count not one");
	word_phase_a: assert property (data_rd && long_reg && !xfer_reg[8] |-> wide)
		else $error("long read body not in words");
	byte_tail_a: assert property (data_rd && long_reg && xfer_reg[8] |-> !wide)
		else $error("long read tail not in bytes");
	long_size_a: assert property (long_reg |-> xfer_reg <= 9'h104) else $error("long read too long");
	long_no_ecc_a: assert property (stat_rd && long_reg |=> !rdata[ata_pkg::ST_ERR])
		else $error("error flagged in long read");
	busy_drq_a: assert property (stat_rd |=> !(rdata[ata_pkg::ST_BSY] && rdata[ata_pkg::ST_DRQ]))
		else $error("busy and data request together");
endmodule : ata_link_assertions
`default_nettype wire

/* File: tb/ata_sector_read_long_tb.sv */
/*
 * bench: ahb master and media source around both ends joined by the link.
 * assumes package, link interface and both ends are compiled before it.
 */
`default_nettype none
module ata_sector_read_long_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd, seed;
	logic        media_req, media_lba_mode, media_valid, media_err;
	logic [27:0] media_lba;
	logic [28:0] exp_lba;
	logic [15:0] media_word, tl;
	logic [8:0]  mcnt;
	logic [7:0]  key;
	int          n_errors, checked, fetch_n, err_at, lba_at;
	logic [7:0]  offs [8] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h24, 8'h28, 8'h40};
	logic [7:0]  rsts [8] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'ha0, 8'h00, 8'h00, 8'h00};
	ata_link_if ata_link_if_i ();
	ata_read_host ata_read_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .irq(irq), .link(ata_link_if_i.host));
	ata_read_device ata_read_device_i (.hclk(hclk), .hresetn(hresetn), .link(ata_link_if_i.device),
		.media_req(media_req), .media_lba(media_lba), .media_lba_mode(media_lba_mode),
		.media_valid(media_valid), .media_word(media_word), .media_err(media_err));
	ata_link_assertions ata_link_assertions_i (.hclk(hclk), .hresetn(hresetn), .stb(ata_link_if_i.stb),
		.we(ata_link_if_i.we), .addr(ata_link_if_i.addr), .wide(ata_link_if_i.wide), .wdata(ata_link_if_i.wdata),
		.ack(ata_link_if_i.ack), .rdata(ata_link_if_i.rdata), .intrq(ata_link_if_i.intrq));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (exp !== got) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic complete_run;
		if (n_errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run
	// hready is taken at rising edges; read data at the edge that ends the data phase
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (!hreadyout);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (!hreadyout);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : ahb
	// words carry the sector's low address byte, so a wrong fetch address shows in the data
	always @(posedge hclk) begin
		if (!media_req)
			mcnt <= 9'h000;
		else if (!mcnt[8])
			mcnt <= mcnt + 9'h001;
		if (media_req && mcnt == 9'h000 && fetch_n == lba_at)
			chk("media_lba", {3'h0, exp_lba}, {3'h0, media_lba_mode, media_lba});
		if (media_req && mcnt == 9'h0ff)
			fetch_n <= fetch_n + 1;
		media_valid <= media_req && !mcnt[8];
		media_word <= {media_lba[7:0] ^ key, mcnt[7:0]};
		media_err <= media_req && mcnt == 9'h0ff && fetch_n == err_at;
	end
	task automatic run(input logic [7:0] cmd, input logic [7:0] cnt, input logic mode, input int ea,
		input logic [1:0] mask);
		logic [7:0] sec, s, dh;
		logic [31:0] st;
		logic lng, bad, ee, fe;
		int ns;
		lng = cmd == ata_pkg::CMD_LONG_RT || cmd == ata_pkg::CMD_LONG_NR;
		bad = cmd[7:2] != 6'h08;
		ns = bad ? 0 : lng ? 1 : cnt;
		sec = {4'h0, seed[3:0]} + 8'h01;
		dh = {1'b1, mode, 2'b10, seed[27:24]};
		s = sec;
		fe = bad;
		key = seed[31:24];
		exp_lba = {mode, dh[3:0], seed[23:8], sec};
		// fetch_n counts every fetch since time zero, across all runs, so both marks are absolute
		lba_at = bad ? -1 : fetch_n;
		err_at = ea < 0 ? -1 : fetch_n + ea;
		seed = lfsr(seed);
		ahb(1'b1, ata_pkg::OFF_IRQ_MASK, {30'h0, mask});
		ahb(1'b1, ata_pkg::OFF_IRQ_STAT, 32'h3);
		ahb(1'b1, ata_pkg::OFF_COUNT, {24'h0, cnt});
		ahb(1'b1, ata_pkg::OFF_SECTOR, {24'h0, sec});
		ahb(1'b1, ata_pkg::OFF_CYL_LO, {24'h0, exp_lba[15:8]});
		ahb(1'b1, ata_pkg::OFF_CYL_HI, {24'h0, exp_lba[23:16]});
		ahb(1'b1, ata_pkg::OFF_DEVHEAD, {24'h0, dh});
		ahb(1'b1, ata_pkg::OFF_CMD, {24'h0, cmd});
		for (int k = 0; k < ns && !fe; k++) begin
			s = sec + k[7:0];
			ee = k == ea && !lng;
			fe = ee;
			st = 32'h0;
			for (int p = 0; p < 600 && !(st[3] || st[0]); p++) begin
				ahb(1'b0, ata_pkg::OFF_STATUS, 32'h0);
				st = rd;
			end
			chk("status_drq", {24'h0, 7'h2c, ee}, st);
			ahb(1'b0, ata_pkg::OFF_IRQ_STAT, 32'h0);
			chk("irq_stat", {30'h0, ee, 1'b1}, rd);
			chk("irq", {31'h0, |(mask & {ee, 1'b1})}, {31'h0, irq});
			ahb(1'b1, ata_pkg::OFF_IRQ_STAT, 32'h3);
			ahb(1'b0, ata_pkg::OFF_IRQ_STAT, 32'h0);
			chk("irq_clear", 32'h0, {rd[31:1], irq});
			for (int i = 0; i < 256; i++) begin
				ahb(1'b0, ata_pkg::OFF_DATA, 32'h0);
				chk("data_word", {16'h0, s ^ key, i[7:0]}, rd);
			end
			for (int i = 0; i < 4 && lng; i++) begin
				ahb(1'b0, ata_pkg::OFF_DATA, 32'h0);
				chk("tail_byte", {24'h0, tl[7:0]}, rd);
				tl = {1'b0, tl[15:1]} ^ (tl[0] ? ata_pkg::LFSR_TAPS : 16'h0000);
			end
		end
		st = 32'h80;
		for (int p = 0; p < 600 && (st[7] || !bad && p == 0 || bad && !st[0]); p++) begin
			ahb(1'b0, ata_pkg::OFF_STATUS, 32'h0);
			st = rd;
		end
		chk("status_end", {24'h0, 7'h28, fe}, st);
		ahb(1'b0, ata_pkg::OFF_SECTOR, 32'h0);
		chk("sector_reg", {24'h0, sec}, rd);
		// the host keeps its own copy; the device's address shows on media_lba
		chk("last_sector", {24'h0, s}, {24'h0, media_lba[7:0]});
		ahb(1'b0, ata_pkg::OFF_ERROR, 32'h0);
		chk("error_reg", bad ? 32'h04 : fe ? 32'h40 : 32'h0, rd);
	endtask : run
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	initial begin
		repeat (60000) @(posedge hclk);
		n_errors++;
		complete_run();
	end
	initial begin
		{hsel, hwrite, hresetn} = 3'h0;
		{htrans, haddr, hwdata, key} = '0;
		seed = 32'h7191c6e3;
		tl = ata_pkg::LFSR_SEED;
		n_errors = 0;
		checked = 0;
		err_at = -1;
		lba_at = -1;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 8; i++) begin
			ahb(1'b0, offs[i], 32'h0);
			chk("reset_value", {24'h0, rsts[i]}, rd);
		end
		run(ata_pkg::CMD_LONG_RT, 8'h01, 1'b0, 0, 2'h3);
		run(ata_pkg::CMD_LONG_NR, 8'h01, 1'b1, -1, 2'h0);
		run(ata_pkg::CMD_READ_RT, 8'h02, 1'b0, -1, 2'h3);
		run(ata_pkg::CMD_READ_NR, 8'h02, 1'b1, 1, 2'h3);
		run(8'h99, 8'h01, 1'b0, -1, 2'h3);
		complete_run();
	end
endmodule : ata_sector_read_long_tb
`default_nettype wire

/* File: verilog/ata_link_if.sv */
/*
 * task file link between controller and flash disk.
 * assumes both ends run on the same hclk.
 */
`default_nettype none
interface ata_link_if;
	logic        stb;   // one-cycle access strobe
	logic        we;    // write access
	logic [2:0]  addr;  // task file address
	logic        wide;  // 16-bit access, else byte
	logic [15:0] wdata; // write data
	logic        ack;   // one-cycle answer
	logic [15:0] rdata; // read data, valid with ack
	logic        intrq; // device interrupt level
	modport host (output stb, we, addr, wide, wdata, input ack, rdata, intrq);
	modport device (input stb, we, addr, wide, wdata, output ack, rdata, intrq);
endinterface : ata_link_if
`default_nettype wire

/* File: verilog/ata_pkg.sv */
/*
 * constants shared by both ends of the sector-read link: task file map,
 * command codes, status and error bit positions, controller register map.
 * assumes nothing of its surroundings.
 */
`default_nettype none
package ata_pkg;
	// task file addresses on the link
	localparam logic [2:0] TF_DATA      = 3'h0;
	localparam logic [2:0] TF_ERROR     = 3'h1;
	localparam logic [2:0] TF_COUNT     = 3'h2;
	localparam logic [2:0] TF_SECTOR    = 3'h3;
	localparam logic [2:0] TF_CYL_LO    = 3'h4;
	localparam logic [2:0] TF_CYL_HI    = 3'h5;
	localparam logic [2:0] TF_DEVHEAD   = 3'h6;
	localparam logic [2:0] TF_STATUS    = 3'h7;
	localparam logic [2:0] SEQ_LAST     = 3'h5;
	// command codes
	localparam logic [7:0] CMD_READ_RT  = 8'h20;
	localparam logic [7:0] CMD_READ_NR  = 8'h21;
	localparam logic [7:0] CMD_LONG_RT  = 8'h22;
	localparam logic [7:0] CMD_LONG_NR  = 8'h23;
	// status and error bits
	localparam int ST_BSY  = 7;
	localparam int ST_DRDY = 6;
	localparam int ST_DSC  = 4;
	localparam int ST_DRQ  = 3;
	localparam int ST_ERR  = 0;
	localparam int ER_UNC  = 6;
	localparam int ER_ABRT = 2;
	localparam int DH_LBA  = 6;
	// sizes and reset values
	localparam int         WORDS        = 256;
	localparam logic [7:0] LAST_WORD    = 8'hff;
	localparam logic [1:0] LAST_TAIL    = 2'h3;
	localparam logic [8:0] FULL_COUNT   = 9'h100;
	localparam logic [8:0] ONE_SECTOR   = 9'h001;
	localparam logic [7:0] LONG_COUNT   = 8'h01;
	localparam logic [7:0] DH_FIXED     = 8'ha0;
	localparam logic [7:0] COUNT_RST    = 8'h01;
	localparam logic [7:0] SECTOR_RST   = 8'h01;
	localparam logic [7:0] SECTORS_PER_TRACK = 8'h20;
	localparam logic [3:0] HEAD_LAST    = 4'hf;
	localparam logic [15:0] LFSR_SEED   = 16'hace1;
	localparam logic [15:0] LFSR_TAPS   = 16'hb400;
	// controller registers on AHB-Lite
	localparam logic [7:0] OFF_CMD      = 8'h00;
	localparam logic [7:0] OFF_COUNT    = 8'h04;
	localparam logic [7:0] OFF_SECTOR   = 8'h08;
	localparam logic [7:0] OFF_CYL_LO   = 8'h0c;
	localparam logic [7:0] OFF_CYL_HI   = 8'h10;
	localparam logic [7:0] OFF_DEVHEAD  = 8'h14;
	localparam logic [7:0] OFF_DATA     = 8'h18;
	localparam logic [7:0] OFF_STATUS   = 8'h1c;
	localparam logic [7:0] OFF_ERROR    = 8'h20;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h24;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
	localparam int IRQ_DEV = 0;
	localparam int IRQ_ERR = 1;
endpackage : ata_pkg
`default_nettype wire

/* File: verilog/ata_read_device.sv */
/*
 * flash disk end: task file, sector read and long sector read commands.
 * assumes a media source that answers media_req with 256 words, the last
 * one carrying media_err, and a host on ata_link_if on the same clock.
 */
`default_nettype none
module ata_read_device (
	input  wire logic        hclk,           // clock
	input  wire logic        hresetn,        // async reset, active low
	ata_link_if.device       link,           // task file link
	output logic             media_req,      // sector fetch in progress
	output logic [27:0]      media_lba,      // lba, or head/cyl/sector
	output logic             media_lba_mode, // media_lba is an lba
	input  wire logic        media_valid,    // media word strobe
	input  wire logic [15:0] media_word,     // media word
	input  wire logic        media_err       // uncorrectable, with last word
);
	typedef enum logic [1:0] {D_IDLE, D_FETCH, D_XFER, D_TAIL} dstate_t;
	typedef struct packed {
		dstate_t     st;
		logic [7:0]  count;
		logic [7:0]  sector;
		logic [7:0]  cyl_lo;
		logic [7:0]  cyl_hi;
		logic [7:0]  devhead;
		logic [7:0]  error;
		logic        bsy;
		logic        drq;
		logic        err;
		logic        intrq;
		logic        abort;
		logic        long_rd;
		logic        ack;
		logic [8:0]  remain;
		logic [7:0]  widx;
		logic [1:0]  tidx;
		logic [15:0] lfsr;
		logic [15:0] rdata;
	} dev_t;

	dev_t        r_reg;
	dev_t        r_next;
	logic [15:0] sector_buf [ata_pkg::WORDS];
	logic        buf_we;
	logic [27:0] lba_next;
	logic [15:0] cyl_next;
	logic [7:0]  status;
	logic [7:0]  opc;
	logic        is_read;
	logic        is_long;

	assign link.ack       = r_reg.ack;
	assign link.rdata     = r_reg.rdata;
	assign link.intrq     = r_reg.intrq;
	assign media_req      = (r_reg.st == D_FETCH);
	assign media_lba      = {r_reg.devhead[3:0], r_reg.cyl_hi, r_reg.cyl_lo, r_reg.sector};
	assign media_lba_mode = r_reg.devhead[ata_pkg::DH_LBA];

	always_comb begin
		r_next   = r_reg;
		buf_we   = 1'b0;
		r_next.ack = link.stb;
		lba_next = media_lba + 28'h1;
		cyl_next = {r_reg.cyl_hi, r_reg.cyl_lo} + 16'h1;
		opc      = link.wdata[7:0];
		is_read  = (opc == ata_pkg::CMD_READ_RT) || (opc == ata_pkg::CMD_READ_NR);
		is_long  = (opc == ata_pkg::CMD_LONG_RT) || (opc == ata_pkg::CMD_LONG_NR);
		status   = 8'h00;
		status[ata_pkg::ST_BSY]  = r_reg.bsy;
		status[ata_pkg::ST_DRDY] = 1'b1;
		status[ata_pkg::ST_DSC]  = 1'b1;
		status[ata_pkg::ST_DRQ]  = r_reg.drq;
		status[ata_pkg::ST_ERR]  = r_reg.err;

		// register reads answer in any state; reading status drops intrq
		if (link.stb && !link.we) begin
			unique case (link.addr)
				ata_pkg::TF_ERROR:   r_next.rdata = {8'h00, r_reg.error};
				ata_pkg::TF_COUNT:   r_next.rdata = {8'h00, r_reg.count};
				ata_pkg::TF_SECTOR:  r_next.rdata = {8'h00, r_reg.sector};
				ata_pkg::TF_CYL_LO:  r_next.rdata = {8'h00, r_reg.cyl_lo};
				ata_pkg::TF_CYL_HI:  r_next.rdata = {8'h00, r_reg.cyl_hi};
				ata_pkg::TF_DEVHEAD: r_next.rdata = {8'h00, r_reg.devhead};
				ata_pkg::TF_STATUS: begin
					r_next.rdata = {8'h00, status};
					r_next.intrq = 1'b0;
				end
				ata_pkg::TF_DATA:    r_next.rdata = 16'h0000;
			endcase
		end

		unique case (r_reg.st)
			D_IDLE: begin
				// writes while busy are dropped so the address stays stable
				if (link.stb && link.we) begin
					unique case (link.addr)
						ata_pkg::TF_COUNT:   r_next.count = link.wdata[7:0];
						ata_pkg::TF_SECTOR:  r_next.sector = link.wdata[7:0];
						ata_pkg::TF_CYL_LO:  r_next.cyl_lo = link.wdata[7:0];
						ata_pkg::TF_CYL_HI:  r_next.cyl_hi = link.wdata[7:0];
						ata_pkg::TF_DEVHEAD: r_next.devhead = link.wdata[7:0] | ata_pkg::DH_FIXED;
						ata_pkg::TF_STATUS: begin
							r_next.error = 8'h00;
							r_next.err   = 1'b0;
							r_next.abort = 1'b0;
							r_next.widx  = 8'h00;
							r_next.tidx  = 2'h0;
							if (is_read || is_long) begin
								r_next.bsy     = 1'b1;
								r_next.long_rd = is_long;
								if (is_long)
									r_next.remain = ata_pkg::ONE_SECTOR;
								else if (r_reg.count == 8'h00)
									r_next.remain = ata_pkg::FULL_COUNT;
								else
									r_next.remain = {1'b0, r_reg.count};
								r_next.st = D_FETCH;
							end else begin
								r_next.err = 1'b1;
								r_next.error[ata_pkg::ER_ABRT] = 1'b1;
								r_next.intrq = 1'b1;
							end
						end
						default: ;
					endcase
				end
			end
			D_FETCH: begin
				if (media_valid) begin
					buf_we      = 1'b1;
					r_next.widx = r_reg.widx + 8'h1;
					if (r_reg.widx == ata_pkg::LAST_WORD) begin
						r_next.drq   = 1'b1;
						// busy drops while data is offered, so the host can tell drq from a stale poll
						r_next.bsy   = 1'b0;
						r_next.intrq = 1'b1;
						r_next.st    = D_XFER;
						// long reads never report ECC trouble
						if (media_err && !r_reg.long_rd) begin
							r_next.err   = 1'b1;
							r_next.error[ata_pkg::ER_UNC] = 1'b1;
							r_next.abort = 1'b1;
						end
					end
				end
			end
			D_XFER: begin
				if (link.stb && !link.we && link.addr == ata_pkg::TF_DATA && link.wide) begin
					r_next.rdata = sector_buf[r_reg.widx];
					r_next.widx  = r_reg.widx + 8'h1;
					if (r_reg.widx == ata_pkg::LAST_WORD) begin
						if (r_reg.long_rd) begin
							r_next.st = D_TAIL;
						end else if (r_reg.abort || r_reg.remain == ata_pkg::ONE_SECTOR) begin
							r_next.drq = 1'b0;
							r_next.bsy = 1'b0;
							r_next.st  = D_IDLE;
						end else begin
							r_next.drq    = 1'b0;
							r_next.bsy    = 1'b1;
							r_next.remain = r_reg.remain - 9'h1;
							r_next.st     = D_FETCH;
							if (r_reg.devhead[ata_pkg::DH_LBA]) begin
								r_next.sector       = lba_next[7:0];
								r_next.cyl_lo       = lba_next[15:8];
								r_next.cyl_hi       = lba_next[23:16];
								r_next.devhead[3:0] = lba_next[27:24];
							end else if (r_reg.sector == ata_pkg::SECTORS_PER_TRACK) begin
								r_next.sector = ata_pkg::SECTOR_RST;
								if (r_reg.devhead[3:0] == ata_pkg::HEAD_LAST) begin
									r_next.devhead[3:0] = 4'h0;
									r_next.cyl_lo = cyl_next[7:0];
									r_next.cyl_hi = cyl_next[15:8];
								end else begin
									r_next.devhead[3:0] = r_reg.devhead[3:0] + 4'h1;
								end
							end else begin
								r_next.sector = r_reg.sector + 8'h1;
							end
						end
					end
				end
			end
			D_TAIL: begin
				// the buffer holds no check bytes, so the tail is lfsr noise
				if (link.stb && !link.we && link.addr == ata_pkg::TF_DATA && !link.wide) begin
					r_next.rdata = {8'h00, r_reg.lfsr[7:0]};
					r_next.lfsr  = {1'b0, r_reg.lfsr[15:1]} ^ (r_reg.lfsr[0] ? ata_pkg::LFSR_TAPS : 16'h0000);
					r_next.tidx  = r_reg.tidx + 2'h1;
					if (r_reg.tidx == ata_pkg::LAST_TAIL) begin
						r_next.drq = 1'b0;
						r_next.bsy = 1'b0;
						r_next.st  = D_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge hclk) begin
		if (buf_we)
			sector_buf[r_reg.widx] <= media_word;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg         <= '0;
			r_reg.count   <= ata_pkg::COUNT_RST;
			r_reg.sector  <= ata_pkg::SECTOR_RST;
			r_reg.devhead <= ata_pkg::DH_FIXED;
			r_reg.lfsr    <= ata_pkg::LFSR_SEED;
		end else begin
			r_reg <= r_next;
		end
	end
endmodule : ata_read_device
`default_nettype wire

/* File: verilog/ata_read_host.sv */
/*
 * controller end: AHB-Lite slave whose registers drive the task file link.
 * assumes a single AHB-Lite master doing whole-word single transfers and a
 * device on ata_link_if on the same clock.
 */
`default_nettype none
module ata_read_host (
	input  wire logic        hclk,      // clock
	input  wire logic        hresetn,   // async reset, active low
	input  wire logic        hsel,      // slave select
	input  wire logic [31:0] haddr,     // byte address
	input  wire logic [1:0]  htrans,    // transfer type
	input  wire logic        hwrite,    // write
	input  wire logic [2:0]  hsize,     // word only
	input  wire logic [31:0] hwdata,    // write data
	input  wire logic        hready,    // bus ready
	output logic [31:0]      hrdata,    // read data
	output logic             hreadyout, // slave ready
	output logic             hresp,     // always okay
	output logic             irq,       // interrupt level
	ata_link_if.host         link       // task file link
);
	typedef enum logic [2:0] {H_IDLE, H_DATA, H_SEQ, H_LINK, H_RESP} hstate_t;
	typedef struct packed {
		hstate_t     st;
		logic [7:0]  off;
		logic        wr;
		logic [7:0]  opcode;
		logic [7:0]  count;
		logic [7:0]  sector;
		logic [7:0]  cyl_lo;
		logic [7:0]  cyl_hi;
		logic [7:0]  devhead;
		logic        long_rd;
		logic [8:0]  xfers;
		logic [2:0]  seq;
		logic        pend;
		logic        stb;
		logic        we;
		logic [2:0]  addr;
		logic        wide;
		logic [15:0] wdata;
		logic [31:0] hrdata;
		logic [1:0]  irq_stat;
		logic [1:0]  irq_mask;
		logic        intrq_d;
	} host_t;

	host_t       r_reg;
	host_t       r_next;
	logic        is_cmd_w;
	logic        is_link_r;
	logic [2:0]  link_addr;
	logic [1:0]  irq_set;

	assign hrdata     = r_reg.hrdata;
	assign hresp      = 1'b0;
	assign irq        = |(r_reg.irq_stat & r_reg.irq_mask);
	assign link.stb   = r_reg.stb;
	assign link.we    = r_reg.we;
	assign link.addr  = r_reg.addr;
	assign link.wide  = r_reg.wide;
	assign link.wdata = r_reg.wdata;

	always_comb begin
		is_cmd_w  = r_reg.wr && r_reg.off == ata_pkg::OFF_CMD;
		is_link_r = !r_reg.wr && (r_reg.off == ata_pkg::OFF_DATA || r_reg.off == ata_pkg::OFF_STATUS
			|| r_reg.off == ata_pkg::OFF_ERROR);
		unique case (r_reg.st)
			H_SEQ, H_LINK: hreadyout = 1'b0;
			H_DATA:        hreadyout = !(is_cmd_w || is_link_r);
			default:       hreadyout = 1'b1;
		endcase
		unique case (r_reg.off)
			ata_pkg::OFF_DATA:   link_addr = ata_pkg::TF_DATA;
			ata_pkg::OFF_STATUS: link_addr = ata_pkg::TF_STATUS;
			default:             link_addr = ata_pkg::TF_ERROR;
		endcase
	end

	always_comb begin
		r_next = r_reg;
		r_next.stb = 1'b0;
		irq_set = 2'b00;
		irq_set[ata_pkg::IRQ_DEV] = link.intrq && !r_reg.intrq_d;
		r_next.intrq_d = link.intrq;
		unique case (r_reg.st)
			H_DATA: begin
				if (r_reg.wr) begin
					unique case (r_reg.off)
						ata_pkg::OFF_CMD: begin
							r_next.opcode  = hwdata[7:0];
							r_next.long_rd = hwdata[7:0] == ata_pkg::CMD_LONG_RT || hwdata[7:0] == ata_pkg::CMD_LONG_NR;
							r_next.xfers   = 9'h000;
							r_next.seq     = 3'h0;
							r_next.pend    = 1'b0;
							r_next.st      = H_SEQ;
						end
						ata_pkg::OFF_COUNT:    r_next.count = hwdata[7:0];
						ata_pkg::OFF_SECTOR:   r_next.sector = hwdata[7:0];
						ata_pkg::OFF_CYL_LO:   r_next.cyl_lo = hwdata[7:0];
						ata_pkg::OFF_CYL_HI:   r_next.cyl_hi = hwdata[7:0];
						ata_pkg::OFF_DEVHEAD:  r_next.devhead = hwdata[7:0];
						ata_pkg::OFF_IRQ_STAT: r_next.irq_stat = r_reg.irq_stat & ~hwdata[1:0];
						ata_pkg::OFF_IRQ_MASK: r_next.irq_mask = hwdata[1:0];
						default: ;
					endcase
				end else if (is_link_r) begin
					r_next.stb   = 1'b1;
					r_next.we    = 1'b0;
					r_next.addr  = link_addr;
					// after 256 words a long read switches to byte reads
					r_next.wide  = !(r_reg.long_rd && r_reg.xfers >= ata_pkg::FULL_COUNT);
					r_next.st    = H_LINK;
				end
			end
			H_SEQ: begin
				if (!r_reg.pend) begin
					r_next.stb  = 1'b1;
					r_next.pend = 1'b1;
					r_next.we   = 1'b1;
					r_next.wide = 1'b0;
					r_next.addr = ata_pkg::TF_COUNT + r_reg.seq;
					unique case (r_reg.seq)
						3'h0: r_next.wdata = {8'h00, r_reg.long_rd ? ata_pkg::LONG_COUNT : r_reg.count};
						3'h1: r_next.wdata = {8'h00, r_reg.sector};
						3'h2: r_next.wdata = {8'h00, r_reg.cyl_lo};
						3'h3: r_next.wdata = {8'h00, r_reg.cyl_hi};
						3'h4: r_next.wdata = {8'h00, r_reg.devhead | ata_pkg::DH_FIXED};
						default: r_next.wdata = {8'h00, r_reg.opcode};
					endcase
				end else if (link.ack) begin
					r_next.pend = 1'b0;
					r_next.seq  = r_reg.seq + 3'h1;
					if (r_reg.seq == ata_pkg::SEQ_LAST)
						r_next.st = H_RESP;
				end
			end
			H_LINK: begin
				if (link.ack) begin
					r_next.hrdata = {16'h0000, link.rdata};
					r_next.st     = H_RESP;
					if (r_reg.addr == ata_pkg::TF_DATA)
						r_next.xfers = r_reg.xfers + 9'h1;
					if (r_reg.addr == ata_pkg::TF_STATUS)
						irq_set[ata_pkg::IRQ_ERR] = link.rdata[ata_pkg::ST_ERR];
				end
			end
			default: ;
		endcase
		// a new event wins over a clear in the same cycle
		r_next.irq_stat = r_next.irq_stat | irq_set;
		if (hreadyout) begin
			if (hready && hsel && htrans[1]) begin
				r_next.st  = H_DATA;
				r_next.off = haddr[7:0];
				r_next.wr  = hwrite;
				unique case (haddr[7:0])
					ata_pkg::OFF_CMD:      r_next.hrdata = {24'h0, r_reg.opcode};
					ata_pkg::OFF_COUNT:    r_next.hrdata = {24'h0, r_reg.count};
					ata_pkg::OFF_SECTOR:   r_next.hrdata = {24'h0, r_reg.sector};
					ata_pkg::OFF_CYL_LO:   r_next.hrdata = {24'h0, r_reg.cyl_lo};
					ata_pkg::OFF_CYL_HI:   r_next.hrdata = {24'h0, r_reg.cyl_hi};
					ata_pkg::OFF_DEVHEAD:  r_next.hrdata = {24'h0, r_reg.devhead};
					ata_pkg::OFF_IRQ_STAT: r_next.hrdata = {30'h0, r_reg.irq_stat};
					ata_pkg::OFF_IRQ_MASK: r_next.hrdata = {30'h0, r_reg.irq_mask};
					default:               r_next.hrdata = 32'h0000_0000;
				endcase
			end else begin
				r_next.st = H_IDLE;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg         <= '0;
			r_reg.count   <= ata_pkg::COUNT_RST;
			r_reg.sector  <= ata_pkg::SECTOR_RST;
			r_reg.devhead <= ata_pkg::DH_FIXED;
		end else begin
			r_reg <= r_next;
		end
	end
endmodule : ata_read_host
`default_nettype wire
